/* design/vel_thresh_monitor.sv */
/*
 per-axis velocity threshold monitor: command decode, threshold store,
 first-order velocity filter and magnitude compare.
 assumes one clock, trajectory sample strobe and velocities from the same domain.
*/
`include "vel_thresh_defs.svh"
module vel_thresh_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host command
    input vel_thresh_pkg::load_cmd_t cmd,
    output vel_thresh_pkg::err_t err_out,
    output logic load_done,
    // variable store write port
    input wire logic var_we,
    input wire logic [6:0] var_addr,
    input wire logic [`VT_VAL_W-1:0] var_data,
    // axis configuration
    input wire logic [`VT_AXES-1:0] axis_is_stepper,
    input wire logic [`VT_FILT_W-1:0] filt_shift,
    // trajectory samples
    input wire logic sample_en,
    input wire logic [`VT_AXES*`VT_VAL_W-1:0] axis_vel,
    // status
    output logic [`VT_AXES-1:0] vel_above
);
    import vel_thresh_pkg::*;

    localparam int W = `VT_VAL_W;
    localparam int FW = W + 16;

    logic [W-1:0] vars [0:`VT_NVARS-1];
    logic [W-1:0] thr_r [0:`VT_AXES-1];
    logic signed [FW-1:0] filt_r [0:`VT_AXES-1];
    src_kind_t kind;
    logic [W-1:0] operand;
    logic [W-1:0] lim;
    logic [W-1:0] ind_ptr;
    logic ok;

    function automatic src_kind_t decode_src(input logic [7:0] s);
        if (s == `VT_SRC_IMM) begin
            return SRC_IMM;
        end else if (s >= `VT_VAR_LO && s <= `VT_VAR_HI) begin
            return SRC_VAR;
        end else if (s >= `VT_IND_LO && s <= `VT_IND_HI) begin
            return SRC_IND;
        end
        return SRC_BAD;
    endfunction : decode_src

    function automatic logic [W-1:0] axis_max(input logic stepper);
        return stepper ? `VT_STEP_MAX : `VT_SERVO_MAX;
    endfunction : axis_max

    function automatic logic [W-1:0] mag(input logic signed [FW-1:0] v);
        logic [FW-1:0] a;
        a = v[FW-1] ? FW'(-v) : FW'(v);
        return a[FW-1:16];
    endfunction : mag

    // one filter step; a guard bit keeps the difference from wrapping
    function automatic logic signed [FW-1:0] filt_step(input logic signed [FW-1:0] f,
        input logic [W-1:0] v, input logic [`VT_FILT_W-1:0] sh);
        logic signed [FW:0] tgt;
        logic signed [FW:0] cur;
        logic signed [FW:0] diff;
        logic signed [FW:0] nxt;
        tgt = signed'({v[W-1], v, 16'h0000});
        cur = signed'({f[FW-1], f});
        diff = (tgt - cur) >>> sh;
        nxt = cur + diff;
        return nxt[FW-1:0];
    endfunction : filt_step

    always_ff @(posedge clk) begin
        if (var_we && var_addr < 7'(`VT_NVARS)) begin
            vars[var_addr] <= var_data;
        end
    end

    // operand fetch; indirect reads a variable that names another variable
    always_comb begin
        kind = decode_src(cmd.src); // (R6)
        ind_ptr = vars[7'(cmd.src[6:0] - 7'h01)];
        case (kind)
            SRC_IMM: operand = cmd.value;
            SRC_VAR: operand = vars[7'(cmd.src[6:0] - 7'h01)];
            SRC_IND: begin
                if (ind_ptr != '0 && ind_ptr <= W'(`VT_NVARS)) begin
                    operand = vars[7'(ind_ptr[6:0] - 7'h01)];
                end else begin
                    operand = '0;
                end
            end
            default: operand = '0;
        endcase
        lim = axis_max(axis_is_stepper[cmd.axis]);
        // out-of-span values are refused rather than clipped
        ok = kind != SRC_BAD && operand != '0 && operand <= lim; // (R1) (R2) (R9)
    end

    // error passthrough: a pending error skips the load
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            err_out <= '0;
            load_done <= 1'b0;
        end else begin
            load_done <= 1'b0;
            if (cmd.valid) begin
                if (cmd.err_status) begin
                    err_out <= '{cmd.err_status, cmd.err_code}; // (R7)
                end else if (!ok) begin
                    err_out <= '{1'b1, `VT_ERR_REFUSED};
                end else begin
                    err_out <= '0;
                    load_done <= 1'b1;
                end
            end
        end
    end

    // thresholds; reset value is the axis maximum so the flag stays off
    always_ff @(posedge clk) begin
        for (int i = 0; i < `VT_AXES; i++) begin
            if (sys_rst) begin
                thr_r[i] <= axis_max(axis_is_stepper[i]); // (R3)
            end else if (cmd.valid && !cmd.err_status && ok && cmd.axis == 3'(i)) begin
                thr_r[i] <= operand; // (R10)
            end
        end
    end

    // velocity filter in 16.16: longer shift, less chatter, more latency
    always_ff @(posedge clk) begin
        for (int i = 0; i < `VT_AXES; i++) begin
            if (sys_rst) begin
                filt_r[i] <= '0;
            end else if (sample_en) begin
                filt_r[i] <= filt_step(filt_r[i], axis_vel[i*W +: W],
                    filt_shift); // (R8) (R11)
            end
        end
    end

    // no enable: compare every cycle; equality reads as off
    // a threshold at the axis maximum parks the flag, whatever the speed
    always_ff @(posedge clk) begin
        for (int i = 0; i < `VT_AXES; i++) begin
            if (sys_rst) begin
                vel_above[i] <= 1'b0;
            end else begin
                vel_above[i] <= mag(filt_r[i]) > thr_r[i] // (R4) (R12)
                    && thr_r[i] < axis_max(axis_is_stepper[i]); // (R5)
            end
        end
    end

    // per-axis checks; limits written out so a wrong maximum is caught
    for (genvar g = 0; g < `VT_AXES; g++) begin : g_axis_chk
        a_flag_tracks: assert property (@(posedge clk) disable iff (sys_rst) // (R4)
            mag(filt_r[g]) > thr_r[g]
            && thr_r[g] < (axis_is_stepper[g] ? `VT_STEP_MAX : `VT_SERVO_MAX)
            |=> vel_above[g])
            else $error("axis flag missing above threshold");

        a_equal_off: assert property (@(posedge clk) disable iff (sys_rst) // (R12)
            mag(filt_r[g]) <= thr_r[g] |=> !vel_above[g])
            else $error("axis flag set at or below threshold");

        a_max_off: assert property (@(posedge clk) disable iff (sys_rst) // (R5)
            thr_r[g] == (axis_is_stepper[g] ? `VT_STEP_MAX : `VT_SERVO_MAX)
            |=> !vel_above[g])
            else $error("flag set at maximum threshold");

        a_reset_max: assert property (@(posedge clk) // (R3)
            $fell(sys_rst)
            |-> thr_r[g] == (axis_is_stepper[g] ? `VT_STEP_MAX : `VT_SERVO_MAX))
            else $error("threshold not at maximum after reset");

        a_filt_direct: assert property (@(posedge clk) disable iff (sys_rst) // (R11)
            sample_en && filt_shift == '0
            |=> filt_r[g] == signed'({$past(axis_vel[g*W +: W]), 16'h0000}))
            else $error("unfiltered sample not held in 16.16");
    end

    a_load_gated: assert property (@(posedge clk) disable iff (sys_rst) // (R7)
        cmd.valid && cmd.err_status |=> !load_done && err_out.err_status)
        else $error("load ran with pending error");

    a_err_passthru: assert property (@(posedge clk) disable iff (sys_rst) // (R7)
        cmd.valid && cmd.err_status
        |=> err_out.err_status && err_out.err_code == $past(cmd.err_code))
        else $error("incoming error not forwarded");

    a_range_refused: assert property (@(posedge clk) disable iff (sys_rst) // (R1)
        cmd.valid && !cmd.err_status && cmd.src == `VT_SRC_IMM
        && !axis_is_stepper[cmd.axis]
        && (cmd.value == '0 || cmd.value > `VT_SERVO_MAX)
        |=> !load_done && err_out.err_status)
        else $error("out of span value accepted");

    a_step_refused: assert property (@(posedge clk) disable iff (sys_rst) // (R2)
        cmd.valid && !cmd.err_status && cmd.src == `VT_SRC_IMM
        && axis_is_stepper[cmd.axis]
        && (cmd.value == '0 || cmd.value > `VT_STEP_MAX)
        |=> !load_done && err_out.err_status)
        else $error("out of span stepper value accepted");

    a_src_refused: assert property (@(posedge clk) disable iff (sys_rst) // (R6)
        cmd.valid && !cmd.err_status
        && (cmd.src == 8'h00 || (cmd.src > `VT_VAR_HI && cmd.src < `VT_IND_LO)
        || (cmd.src > `VT_IND_HI && cmd.src != `VT_SRC_IMM))
        |=> !load_done && err_out.err_status)
        else $error("reserved operand source accepted");

    a_imm_taken: assert property (@(posedge clk) disable iff (sys_rst) // (R10)
        cmd.valid && !cmd.err_status && cmd.src == `VT_SRC_IMM
        && cmd.value != '0 && cmd.value <= `VT_STEP_MAX
        |=> load_done && !err_out.err_status)
        else $error("legal load refused");

    a_reset_quiet: assert property (@(posedge clk) // (R3)
        $fell(sys_rst) |-> vel_above == '0 && !load_done && !err_out.err_status)
        else $error("outputs not cleared by reset");
endmodule : vel_thresh_monitor

/* pkg/vel_thresh_defs.svh */
/*
 constants of the per-axis velocity threshold monitor.
 assumes a 250 MHz clock and a host command port on the same clock.
*/
// Functional notes
// (R1) servo threshold in counts/s, legal 1 to 16,000,000.
// (R2) stepper threshold in steps/s, legal 1 to 1,500,000.
// (R3) after reset each axis threshold holds its maximum, monitor idle.
// (R4) flag high while filtered speed magnitude exceeds threshold, low below it.
// (R5) comparison always runs; maximum threshold keeps flag permanently low.
// (R6) source 0xff immediate, 0x01-0x78 variable, 0x81-0xf8 indirect variable.
// (R7) host loads only without pending error, else forwards error unchanged.
// (R8) compared velocity passes a configurable filter; longer constant, more latency.
// (R9) revolutions-per-minute threshold is positive double, range set by axis scaling.
// (R10) each axis owns its threshold and flag, readable in trajectory status.
// (R11) per-minute velocities become 16.16 counts per sample period before use.
// (R12) magnitude equal to threshold reads deasserted; no extra hysteresis.
`ifndef VEL_THRESH_DEFS_SVH
`define VEL_THRESH_DEFS_SVH
`define VT_AXES 8
`define VT_VAL_W 24
`define VT_SERVO_MAX 24'hf42400
`define VT_STEP_MAX 24'h16e360
`define VT_ERR_REFUSED 16'h0001
`define VT_SRC_IMM 8'hff
`define VT_VAR_LO 8'h01
`define VT_VAR_HI 8'h78
`define VT_IND_LO 8'h81
`define VT_IND_HI 8'hf8
`define VT_NVARS 120
`define VT_FILT_W 4
`endif

/* pkg/vel_thresh_pkg.sv */
/*
 types of the velocity threshold monitor.
 assumes vel_thresh_defs.svh is on the include path.
*/
`include "vel_thresh_defs.svh"
package vel_thresh_pkg;
    typedef enum logic [1:0] {
        SRC_IMM = 2'b00,
        SRC_VAR = 2'b01,
        SRC_IND = 2'b10,
        SRC_BAD = 2'b11
    } src_kind_t;
    typedef struct packed {
        logic valid;
        logic [2:0] axis;
        logic [7:0] src;
        logic [`VT_VAL_W-1:0] value;
        logic err_status;
        logic [15:0] err_code;
    } load_cmd_t;
    typedef struct packed {
        logic err_status;
        logic [15:0] err_code;
    } err_t;
endpackage : vel_thresh_pkg

/* verif/axis_velocity_threshold_monitor_tb.sv */
/*
 self-checking bench for the velocity threshold monitor.
 assumes filt_shift is changed only between samples.
*/
module axis_velocity_threshold_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vel_thresh_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    load_cmd_t cmd;
    err_t err_out;
    logic load_done, var_we;
    logic [6:0] var_addr;
    logic [23:0] var_data;
    logic [7:0] axis_is_stepper = 8'h20;
    logic [3:0] filt_shift = 4'h0;
    logic sample_en = 1'b0;
    logic [191:0] axis_vel = '0;
    logic [7:0] vel_above;
    int error_cnt = 0;
    int n_tests = 0;
    always #2 clk = ~clk;
    vel_thresh_monitor i_dut (.clk, .sys_rst, .cmd, .err_out, .load_done, .var_we,
        .var_addr, .var_data, .axis_is_stepper, .filt_shift, .sample_en, .axis_vel,
        .vel_above);
    host_model u_host (.clk, .cmd, .var_we, .var_addr, .var_data);
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic load(input logic [2:0] a, input logic [7:0] s, input logic [23:0] v,
        input logic [16:0] ein, input logic [17:0] exp);
        u_host.send(a, s, v, ein);
        chk({load_done, err_out}, exp);
    endtask : load
    // same velocity on every axis, so each flag shows its own threshold
    task automatic samp(input logic [23:0] v, input logic [7:0] exp);
        @(posedge clk) #1;
        {sample_en, axis_vel} = {1'b1, {8{v}}};
        @(posedge clk) #1;
        sample_en = 1'b0;
        @(posedge clk) #1;
        chk(vel_above, exp);
    endtask : samp
    task automatic t_reset;
        chk({load_done, err_out}, 24'h000000);
        samp(24'd1500000, 8'h00);
        samp(-24'sd1500000, 8'h00);
        // faster than the stepper maximum, yet a parked threshold keeps the flag low
        samp(24'd2000000, 8'h00);
    endtask : t_reset
    task automatic t_imm;
        load(3'd2, 8'hff, 24'd1000, 17'h00000, 18'h20000);
        samp(24'd1001, 8'h04);
        samp(-24'sd1001, 8'h04);
        samp(24'd1000, 8'h00);
    endtask : t_imm
    task automatic t_refuse;
        load(3'd2, 8'hff, 24'd5, 17'h11234, 18'h11234);
        load(3'd2, 8'hff, 24'd0, 17'h00000, 18'h10001);
        load(3'd2, 8'hff, 24'd16000001, 17'h00000, 18'h10001);
        load(3'd5, 8'hff, 24'd1500001, 17'h00000, 18'h10001);
        load(3'd2, 8'h00, 24'd7, 17'h00000, 18'h10001);
        load(3'd2, 8'h79, 24'd7, 17'h00000, 18'h10001);
        load(3'd5, 8'hff, 24'd1500000, 17'h00000, 18'h20000);
        load(3'd0, 8'hff, 24'd16000000, 17'h00000, 18'h20000);
        load(3'd1, 8'hff, 24'd1, 17'h00000, 18'h20000);
        samp(24'd1001, 8'h06);
    endtask : t_refuse
    task automatic t_src;
        u_host.wvar(7'h04, 24'd500);
        u_host.wvar(7'h00, 24'd7);
        u_host.wvar(7'h06, 24'd200);
        u_host.wvar(7'h77, 24'd7);
        load(3'd3, 8'h05, 24'd0, 17'h00000, 18'h20000);
        load(3'd4, 8'h81, 24'd0, 17'h00000, 18'h20000);
        load(3'd6, 8'hf8, 24'd0, 17'h00000, 18'h20000);
        load(3'd7, 8'h78, 24'd0, 17'h00000, 18'h20000);
        samp(24'd201, 8'hd2);
    endtask : t_src
    // a slow filter must hold axis 2 below its threshold after one fast sample;
    // a step down must pull the positive average down, not wrap it
    task automatic t_filter;
        filt_shift = 4'h4;
        samp(24'd2000, 8'hd2);
        samp(-24'sd2000, 8'h82);
    endtask : t_filter
    task automatic print_verdict;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_imm();
        t_refuse();
        t_src();
        t_filter();
        print_verdict();
    end
endmodule : axis_velocity_threshold_monitor_tb

/* verif/host_model.sv */
/*
 host side model: issues threshold loads and variable writes.
 assumes the monitor samples on the rising edge of clk.
*/
`include "vel_thresh_defs.svh"
module host_model (
    // clock
    input wire logic clk,
    // command and variable store
    output vel_thresh_pkg::load_cmd_t cmd,
    output logic var_we,
    output logic [6:0] var_addr,
    output logic [`VT_VAL_W-1:0] var_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import vel_thresh_pkg::*;
    initial begin
        cmd = '0;
        var_we = 1'b0;
        var_addr = 7'h00;
        var_data = '0;
    end
    // error cluster rides with the request; released fields are inverted, not held
    task automatic send(input logic [2:0] ax, input logic [7:0] src,
        input logic [23:0] val, input logic [16:0] ein);
        @(posedge clk) #1;
        cmd = {1'b1, ax, src, val, ein};
        @(posedge clk) #1;
        cmd = {1'b0, ~cmd[$bits(cmd)-2:0]};
    endtask : send
    task automatic wvar(input logic [6:0] a, input logic [23:0] d);
        @(posedge clk) #1;
        {var_we, var_addr, var_data} = {1'b1, a, d};
        @(posedge clk) #1;
        {var_we, var_addr, var_data} = {1'b0, ~a, ~d};
    endtask : wvar
endmodule : host_model
